// ---- common/spisl_regs.vh ----
// Constants for the SPI slave register access block.
// Assumes inclusion by the design files only; holds definitions, no logic.
`ifndef SPISL_REGS_VH
`define SPISL_REGS_VH

// ----------------------------------------
// Serial config register fields
// ----------------------------------------
`define SPISL_CFG_ADDR 7'h00
`define SPISL_CFG_RESET 8'h00
`define SPISL_CFG_3WIRE_BIT 7
`define SPISL_CFG_AUTOINC_BIT 6

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SPISL_RW_BIT 7
`define SPISL_ADDR_W 7
`define SPISL_DATA_W 8
`define SPISL_NUM_REGS 128

`endif

// ---- rtl/spisl_sync.v ----
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to clk; first stage feeds only the second.
`timescale 1ns/1ps
module spisl_sync #(
    parameter W = 3
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ---- rtl/spisl_top.v ----
// SPI slave giving a host byte access to 128 registers, the config register at address 0.
// Assumes MCLK well above 4x the serial clock; pins are asynchronous.
//
// Operation
// - Config bit7 set selects 3-wire mode
// - Accept modes 0 and 3 automatically
// - Sample data on rising clock edge
// - Change driven data on falling edge
// - Shift all bytes MSB first
// - First byte: read flag, seven-bit address
// - Seven-bit addresses, eight-bit data bytes
// - Single and burst reads and writes
// - Auto-increment off keeps address fixed
// - Auto-increment on advances address per byte
// - Auto-increment resets to zero
// - 3-wire read: master command, device data
// - Shared pin direction follows wire mode
`timescale 1ns/1ps
`include "spisl_regs.vh"
module spisl_top (
    // Clock and reset
    input wire MCLK,
    input wire NRST,
    // Serial pins
    input wire SERIAL_CLOCK_PIN,
    input wire CS_N,
    input wire SERIAL_IN_LINE_I,
    output reg SERIAL_IN_LINE_O,
    output reg SERIAL_IN_LINE_OE,
    output reg SERIAL_OUT_LINE_O,
    output reg SERIAL_OUT_LINE_OE,
    // Status
    output reg THREE_WIRE,
    output reg ADDR_AUTOINC,
    output reg BUSY
);
    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    // Select is inverted ahead of the flops so that their reset value reads
    // as deselected; a plain copy would fake a short frame after every reset.
    wire [2:0] pin_s;
    reg sck_prev_q;
    wire sck_s = pin_s[0];
    wire sel_s = pin_s[1];
    wire sdi_s = pin_s[2];

    spisl_sync #(.W(3)) u_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .d({SERIAL_IN_LINE_I, ~CS_N, SERIAL_CLOCK_PIN}),
        .q(pin_s)
    );

    // Edges seen after sync; in mode 3 the first falling edge has no data
    // pending, so both modes behave alike without a mode bit.
    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg [`SPISL_DATA_W-1:0] regs_q [0:`SPISL_NUM_REGS-1];
    wire [`SPISL_DATA_W-1:0] cfg = regs_q[`SPISL_CFG_ADDR];
    wire cfg_3wire = cfg[`SPISL_CFG_3WIRE_BIT];
    wire cfg_autoinc = cfg[`SPISL_CFG_AUTOINC_BIT];

    // ----------------------------------------
    // Transaction state
    // ----------------------------------------
    // Waiting for the command byte, taking write bytes, or sending read bytes
    localparam ST_CMD = 2'h0;
    localparam ST_WR = 2'h1;
    localparam ST_RD = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [2:0] bit_cnt_q;
    reg [2:0] bit_cnt_d;

    reg [`SPISL_ADDR_W-1:0] addr_q;
    reg [`SPISL_ADDR_W-1:0] addr_d;
    reg [`SPISL_DATA_W-1:0] shin_q;
    reg [`SPISL_DATA_W-1:0] shin_d;
    reg [`SPISL_DATA_W-1:0] shout_q;
    reg [`SPISL_DATA_W-1:0] shout_d;
    reg drive_q;
    reg drive_d;

    reg wr_en_q;
    reg wr_en_d;
    reg [`SPISL_ADDR_W-1:0] wr_addr_q;
    reg [`SPISL_ADDR_W-1:0] wr_addr_d;
    reg [`SPISL_DATA_W-1:0] wr_data_q;
    reg [`SPISL_DATA_W-1:0] wr_data_d;

    wire [`SPISL_DATA_W-1:0] byte_in = {shin_q[`SPISL_DATA_W-2:0], sdi_s};
    wire [`SPISL_ADDR_W-1:0] addr_next = cfg_autoinc ? addr_q + 7'h01 : addr_q;
    // A byte completes on the eighth rising edge since select or the last byte
    wire byte_done = sel_s & sck_rise & (bit_cnt_q == 3'h7);
    // Read bits leave on falling edges only once a read command is decoded
    wire out_load = sel_s & sck_fall & (state_q == ST_RD);

    always @* begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        addr_d = addr_q;
        shin_d = shin_q;
        shout_d = shout_q;
        drive_d = drive_q;
        wr_en_d = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        if (!sel_s) begin
            // Abort drops any partial byte
            state_d = ST_CMD;
            bit_cnt_d = 3'h0;
            drive_d = 1'b0;
        end else begin
            if (sck_rise) begin
                shin_d = byte_in;
                bit_cnt_d = bit_cnt_q + 3'h1;
            end
            if (byte_done) begin
                case (state_q)
                    ST_CMD: begin
                        state_d = byte_in[`SPISL_RW_BIT] ? ST_RD : ST_WR;
                        addr_d = byte_in[`SPISL_ADDR_W-1:0];
                        shout_d = regs_q[byte_in[`SPISL_ADDR_W-1:0]];
                    end
                    ST_WR: begin
                        wr_en_d = 1'b1;
                        wr_addr_d = addr_q;
                        wr_data_d = byte_in;
                        addr_d = addr_next;
                    end
                    ST_RD: begin
                        addr_d = addr_next;
                        shout_d = regs_q[addr_next];
                    end
                    default: begin
                        state_d = ST_CMD;
                    end
                endcase
            end
            if (out_load) begin
                // Read byte leaves MSB first, one bit per falling edge
                drive_d = 1'b1;
                shout_d = {shout_q[`SPISL_DATA_W-2:0], 1'b0};
            end
        end
    end

    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sck_prev_q <= 1'b0;
            state_q <= ST_CMD;
            bit_cnt_q <= 3'h0;
            addr_q <= 7'h00;
            shin_q <= 8'h00;
            shout_q <= 8'h00;
            drive_q <= 1'b0;
            wr_en_q <= 1'b0;
            wr_addr_q <= 7'h00;
            wr_data_q <= 8'h00;
        end else begin
            sck_prev_q <= sck_s;
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            addr_q <= addr_d;
            shin_q <= shin_d;
            shout_q <= shout_d;
            drive_q <= drive_d;
            wr_en_q <= wr_en_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SPISL_NUM_REGS; gi = gi + 1) begin : g_reg
            always @(posedge MCLK or negedge NRST) begin
                if (!NRST) begin
                    regs_q[gi] <= (gi == `SPISL_CFG_ADDR) ? `SPISL_CFG_RESET : 8'h00;
                end else if (wr_en_q && wr_addr_q == gi) begin
                    regs_q[gi] <= wr_data_q;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Pin and status outputs
    // ----------------------------------------
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            SERIAL_IN_LINE_O <= 1'b0;
            SERIAL_IN_LINE_OE <= 1'b0;
            SERIAL_OUT_LINE_O <= 1'b0;
            SERIAL_OUT_LINE_OE <= 1'b0;
            THREE_WIRE <= 1'b0;
            ADDR_AUTOINC <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            if (out_load) begin
                // Both pins carry the bit; only the enabled one reaches the host
                SERIAL_OUT_LINE_O <= shout_q[`SPISL_DATA_W-1];
                SERIAL_IN_LINE_O <= shout_q[`SPISL_DATA_W-1];
            end
            // Next-cycle enable: one MCLK of lag, far inside a serial half-period
            SERIAL_IN_LINE_OE <= drive_q & cfg_3wire & sel_s;
            SERIAL_OUT_LINE_OE <= drive_q & ~cfg_3wire & sel_s;
            THREE_WIRE <= cfg_3wire;
            ADDR_AUTOINC <= cfg_autoinc;
            BUSY <= sel_s;
        end
    end

endmodule

// ---- testbench/spisl_chk.sv ----
// Port checker for spisl_top.
// Assumes a bind onto spisl_top.
`timescale 1ns/1ps
module spisl_chk (
    input wire MCLK,
    input wire NRST,
    input wire SERIAL_CLOCK_PIN,
    input wire CS_N,
    input wire SERIAL_IN_LINE_OE,
    input wire SERIAL_OUT_LINE_O,
    input wire SERIAL_OUT_LINE_OE,
    input wire THREE_WIRE,
    input wire BUSY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    sequence s_idle; !BUSY [*4]; endsequence
    sequence s_high; (SERIAL_OUT_LINE_OE && SERIAL_CLOCK_PIN) [*4]; endsequence
    property p_off; s_idle |-> !SERIAL_OUT_LINE_OE && !SERIAL_IN_LINE_OE; endproperty
    property p_chg; s_high |-> $stable(SERIAL_OUT_LINE_O); endproperty
    property p_rel; $rose(CS_N) |-> ##[1:5] !BUSY; endproperty
    property p_sel; $fell(CS_N) |-> ##[1:5] BUSY; endproperty
    property p_4w; SERIAL_OUT_LINE_OE |-> !THREE_WIRE; endproperty
    property p_3w; SERIAL_IN_LINE_OE |-> THREE_WIRE; endproperty
    property p_one; !(SERIAL_OUT_LINE_OE && SERIAL_IN_LINE_OE); endproperty
    property p_cfg; $changed(THREE_WIRE) |-> BUSY; endproperty
    a_off: assert property (p_off) else $error("line driven idle");
    a_chg: assert property (p_chg) else $error("data moved high");
    a_rel: assert property (p_rel) else $error("busy stuck");
    a_sel: assert property (p_sel) else $error("no busy");
    a_4w: assert property (p_4w) else $error("out in 3w");
    a_3w: assert property (p_3w) else $error("sdio in 4w");
    a_one: assert property (p_one) else $error("two drivers");
    a_cfg: assert property (p_cfg) else $error("cfg moved idle");
endmodule
bind spisl_top spisl_chk chk_u (.MCLK(MCLK), .NRST(NRST), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .CS_N(CS_N),
    .SERIAL_IN_LINE_OE(SERIAL_IN_LINE_OE), .SERIAL_OUT_LINE_O(SERIAL_OUT_LINE_O),
    .SERIAL_OUT_LINE_OE(SERIAL_OUT_LINE_OE), .THREE_WIRE(THREE_WIRE), .BUSY(BUSY));

// ---- testbench/spisl_host.sv ----
// SPI master model.
// Assumes the bench resolves the shared line into miso.
`timescale 1ns/1ps
module spisl_host (
    output logic sclk,
    output logic cs_n,
    output logic h_d,
    output logic h_oe,
    input wire miso
);
    logic cpol, three;
    logic [7:0] wb [3], rb [3];
    initial {sclk, cs_n, h_d, h_oe, cpol, three} = 6'h14;
    task automatic frame(input logic [7:0] c, input int n, input int cut);
        sclk = cpol;
        #80 cs_n = 1'b0;
        #80;
        for (int i = 0; i < 8 * n + 8 && i != cut; i++) begin
            sclk = 1'b0;
            h_oe = !(three && c[7] && i > 7);
            h_d = i < 8 ? c[7 - i] : wb[i / 8 - 1][7 - i % 8];
            #80 sclk = 1'b1;
            // Sampled late in the high phase: device data lags the fall by a few clocks
            #80 if (i > 7) rb[i / 8 - 1][7 - i % 8] = miso;
        end
        sclk = cpol;
        #80 cs_n = 1'b1;
        #320;
    endtask
endmodule

// ---- testbench/tb_spisl_top.sv ----
// Bench for spisl_top: random bursts in both wire modes and in clock modes 0 and 3.
// Assumes spisl_host as master and spisl_chk bound.
`timescale 1ns/1ps
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t bad %h", $time, a); end end
module tb_spisl_top;
    logic mclk = 0, nrst = 0, sclk, cs_n, h_d, h_oe, in_o, in_oe, out_o, out_oe, tw, ai, busy, sdio, miso;
    logic [7:0] cfg;
    logic [6:0] a;
    int error_cnt = 0, check_count = 0, cyc = 0;
    always #10 mclk = ~mclk;
    assign sdio = h_oe ? h_d : in_oe ? in_o : ~in_o;
    assign miso = host_u.three ? sdio : out_oe ? out_o : ~out_o;
    spisl_host host_u (.sclk(sclk), .cs_n(cs_n), .h_d(h_d), .h_oe(h_oe), .miso(miso));
    spisl_top dut_u (.MCLK(mclk), .NRST(nrst), .SERIAL_CLOCK_PIN(sclk), .CS_N(cs_n), .SERIAL_IN_LINE_I(sdio),
        .SERIAL_IN_LINE_O(in_o), .SERIAL_IN_LINE_OE(in_oe), .SERIAL_OUT_LINE_O(out_o),
        .SERIAL_OUT_LINE_OE(out_oe), .THREE_WIRE(tw), .ADDR_AUTOINC(ai), .BUSY(busy));
    function automatic int pick(int k, logic inc);
        return inc ? k : 2;
    endfunction
    task automatic run(logic [7:0] c, int n, int cut);
        @(posedge mclk);
        #1 host_u.frame(c, n, cut);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) if (++cyc == 40000) begin error_cnt++; end_sim(); end
    initial begin
        void'($urandom(12306));
        repeat (2) @(posedge mclk);
        #1 nrst = 1;
        repeat (3) @(posedge mclk);
        #1 `CK({tw, ai}, 2'h0)
        for (int m = 0; m < 4; m++) begin
            cfg = {m[1:0], 6'h00};
            host_u.cpol = m[0] ^ m[1];
            host_u.wb[0] = cfg;
            run(8'h00, 1, -1);
            `CK({tw, ai}, cfg[7:6])
            host_u.three = m[1];
            a = 7'($urandom_range(1, 125));
            for (int k = 0; k < 3; k++) host_u.wb[k] = 8'($urandom);
            run({1'b0, a}, 3, -1);
            // Select dropped mid-command: next frame must decode cleanly
            run({1'b1, a}, 1, 4);
            run({1'b1, a}, 3, -1);
            for (int k = 0; k < 3; k++) `CK(host_u.rb[k], host_u.wb[pick(k, m[0])])
            run(8'h80, 1, -1);
            `CK(host_u.rb[0], cfg)
        end
        end_sim();
    end
endmodule
